// File: rtl/dmahp_top.v
// DMA handshake port: one external DMA channel with register port.
// Assumes all pins are synchronous to CLK_SYS and that the bus master
// of the register port never issues read and write in one cycle.
//
// Overview of operation
// - Only a falling request starts a transfer.
// - Handshake mode: grant strobes external data.
// - External mode drives address, strobes, selects, grant.
// - Paced mode: plain bus cycle, no grant.
// - Request held low holds off write completion.
// - Request held low prolongs read per cycle.
// - Grant stretched by programmed wait states.
// - Hold or idle adds one cycle after grant.
// - Request sampled on the processor clock.
// - Strobes nested inside the grant, except in paced mode.
`timescale 1ns/10ps
`include "dmahp_consts.vh"
module dmahp_top (
    input wire CLK_SYS,
    input wire RST,
    input wire [2:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [31:0] REG_RDATA,
    input wire DMA_REQUEST_N,
    input wire ACK,
    input wire [31:0] DATA_IN,
    output reg [31:0] DATA_OUT,
    output reg DATA_OE,
    output reg [31:0] ADDR_OUT,
    output reg RD_N,
    output reg WR_N,
    output reg SYNC_WRITE_SELECT_N,
    output reg PAGE,
    output reg [3:0] MEMORY_SELECT_N,
    output reg DMA_GRANT_N
);
    reg [3:0] ctrl_r;
    reg [3:0] wait_r;
    reg [31:0] addr_r;
    reg [31:0] count_r;
    reg [31:0] wdata_r;
    reg [31:0] rdata_r;
    reg done_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [2:0] wait_cnt_r;
    reg [2:0] wait_cnt_nxt;
    reg [23:0] last_page_r;
    reg page_nxt;
    wire req_low;
    wire req_fall;
    wire enable;
    wire [1:0] mode;
    wire to_ext;
    wire hold_idle;
    wire ack_ok;
    wire start;
    wire finish;
    wire strobe_mode;
    wire grant_mode;
    wire in_xfer_nxt;
    wire strobe_nxt;
    wire [3:0] ms_dec;
    wire wr_ctrl;
    wire wr_count;

    dmahp_req_detect u_req (
        .clk_sys(CLK_SYS),
        .rst(RST),
        .dma_request_n(DMA_REQUEST_N),
        .req_low(req_low),
        .req_fall(req_fall)
    );

    // ---------------------------------------------------------------
    // Configuration decode
    // ---------------------------------------------------------------
    assign enable = ctrl_r[`DMAHP_CTRL_EN];
    assign mode = ctrl_r[`DMAHP_CTRL_MODE_HI:`DMAHP_CTRL_MODE_LO];
    assign to_ext = ctrl_r[`DMAHP_CTRL_DIR];
    assign hold_idle = wait_r[`DMAHP_WAIT_HOLD];
    // Plain handshake has no acknowledge; the other two modes wait for it.
    assign ack_ok = (mode == `DMAHP_MODE_HS) | ACK;
    assign strobe_mode = (mode != `DMAHP_MODE_HS);
    assign grant_mode = (mode != `DMAHP_MODE_PACED);
    assign start = enable & req_fall & (count_r != `DMAHP_ZERO32);
    // A request still low keeps the access open: a write is held off and
    // a read is prolonged by one clock for every further low cycle.
    assign finish = (wait_cnt_r == `DMAHP_WAIT_ZERO) & ack_ok & ~req_low;
    assign wr_ctrl = REG_WR & (REG_ADDR == `DMAHP_REG_CTRL);
    assign wr_count = REG_WR & (REG_ADDR == `DMAHP_REG_COUNT);

    // ---------------------------------------------------------------
    // Transfer sequencer
    // ---------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        wait_cnt_nxt = wait_cnt_r;
        case (state_r)
            `DMAHP_ST_IDLE: begin
                if (start) begin
                    state_nxt = `DMAHP_ST_ACCESS;
                    wait_cnt_nxt = wait_r[`DMAHP_WAIT_CNT_HI:0];
                end
            end
            `DMAHP_ST_ACCESS: begin
                if (wait_cnt_r != `DMAHP_WAIT_ZERO) begin
                    wait_cnt_nxt = wait_cnt_r - `DMAHP_WAIT_ONE;
                end else if (finish) begin
                    state_nxt = `DMAHP_ST_END;
                end
            end
            `DMAHP_ST_END: begin
                if (hold_idle) begin
                    state_nxt = `DMAHP_ST_GAP;
                end else begin
                    state_nxt = `DMAHP_ST_IDLE;
                end
            end
            `DMAHP_ST_GAP: begin
                state_nxt = `DMAHP_ST_IDLE;
            end
            default: begin
                state_nxt = `DMAHP_ST_IDLE;
            end
        endcase
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            state_r <= `DMAHP_ST_IDLE;
            wait_cnt_r <= `DMAHP_WAIT_ZERO;
        end else begin
            state_r <= state_nxt;
            wait_cnt_r <= wait_cnt_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Pin drive, registered from the next state
    // ---------------------------------------------------------------
    // The grant covers ACCESS and END, the strobes only ACCESS, so a strobe
    // falls with the grant and rises one clock before it.
    assign in_xfer_nxt = (state_nxt == `DMAHP_ST_ACCESS) | (state_nxt == `DMAHP_ST_END);
    assign strobe_nxt = (state_nxt == `DMAHP_ST_ACCESS) & strobe_mode;
    assign ms_dec = ~(4'h1 << addr_r[`DMAHP_MS_HI:`DMAHP_MS_LO]);

    always @* begin
        page_nxt = 1'b0;
        if (strobe_nxt & (addr_r[31:`DMAHP_PAGE_LO] != last_page_r)) begin
            page_nxt = 1'b1;
        end
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            DMA_GRANT_N <= 1'b1;
            RD_N <= 1'b1;
            WR_N <= 1'b1;
            SYNC_WRITE_SELECT_N <= 1'b1;
            PAGE <= 1'b0;
            MEMORY_SELECT_N <= `DMAHP_MS_NONE;
            ADDR_OUT <= `DMAHP_ZERO32;
            DATA_OUT <= `DMAHP_ZERO32;
            DATA_OE <= 1'b0;
            last_page_r <= `DMAHP_PAGE_RST;
        end else begin
            // In plain handshake the grant alone latches or enables data.
            DMA_GRANT_N <= ~(in_xfer_nxt & grant_mode);
            RD_N <= ~(strobe_nxt & ~to_ext);
            WR_N <= ~(strobe_nxt & to_ext);
            SYNC_WRITE_SELECT_N <= ~(strobe_nxt & to_ext);
            PAGE <= page_nxt;
            if (strobe_nxt) begin
                MEMORY_SELECT_N <= ms_dec;
            end else begin
                MEMORY_SELECT_N <= `DMAHP_MS_NONE;
            end
            if (in_xfer_nxt & strobe_mode) begin
                ADDR_OUT <= addr_r;
            end
            if (start) begin
                DATA_OUT <= wdata_r;
            end
            DATA_OE <= in_xfer_nxt & to_ext;
            if (page_nxt) begin
                last_page_r <= addr_r[31:`DMAHP_PAGE_LO];
            end
        end
    end

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    // A software write to ADDR or COUNT wins over the per-word update, so
    // reprogramming a running channel takes effect at once.
    always @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_r <= `DMAHP_CTRL_RST;
            wait_r <= `DMAHP_WAIT_RST;
            addr_r <= `DMAHP_ZERO32;
            count_r <= `DMAHP_ZERO32;
            wdata_r <= `DMAHP_ZERO32;
            rdata_r <= `DMAHP_ZERO32;
            done_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= REG_WDATA[3:0];
            end
            if (REG_WR & (REG_ADDR == `DMAHP_REG_WAIT)) begin
                wait_r <= REG_WDATA[3:0];
            end
            if (REG_WR & (REG_ADDR == `DMAHP_REG_WDATA)) begin
                wdata_r <= REG_WDATA;
            end
            if (REG_WR & (REG_ADDR == `DMAHP_REG_ADDR)) begin
                addr_r <= REG_WDATA;
            end else if ((state_r == `DMAHP_ST_ACCESS) & (state_nxt == `DMAHP_ST_END)) begin
                addr_r <= addr_r + `DMAHP_ONE32;
            end
            if (wr_count) begin
                count_r <= REG_WDATA;
            end else if ((state_r == `DMAHP_ST_ACCESS) & (state_nxt == `DMAHP_ST_END)) begin
                count_r <= count_r - `DMAHP_ONE32;
            end
            if ((state_r == `DMAHP_ST_ACCESS) & (state_nxt == `DMAHP_ST_END) & ~to_ext) begin
                rdata_r <= DATA_IN;
            end
            // The set beats a CTRL-write clear in the same cycle; a COUNT write in that cycle blocks the set.
            if ((state_r == `DMAHP_ST_ACCESS) & (state_nxt == `DMAHP_ST_END) &
                (count_r == `DMAHP_ONE32) & ~wr_count) begin
                done_r <= 1'b1;
            end else if (wr_count | wr_ctrl) begin
                done_r <= 1'b0;
            end
        end
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            REG_RDATA <= `DMAHP_ZERO32;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `DMAHP_REG_CTRL: REG_RDATA <= {28'h0000000, ctrl_r};
                `DMAHP_REG_WAIT: REG_RDATA <= {28'h0000000, wait_r};
                `DMAHP_REG_ADDR: REG_RDATA <= addr_r;
                `DMAHP_REG_COUNT: REG_RDATA <= count_r;
                `DMAHP_REG_WDATA: REG_RDATA <= wdata_r;
                `DMAHP_REG_RDATA: REG_RDATA <= rdata_r;
                `DMAHP_REG_STATUS: REG_RDATA <= {28'h0000000, state_r, done_r,
                                                 (state_r != `DMAHP_ST_IDLE)};
                default: REG_RDATA <= `DMAHP_ZERO32;
            endcase
        end else begin
            REG_RDATA <= `DMAHP_ZERO32;
        end
    end
endmodule

// File: include/dmahp_consts.vh
// Constants of the DMA handshake port: register map, field positions,
// modes, states and reset values.
// Included by dmahp_top only, not by the request sampler; holds definitions only.
`ifndef DMAHP_CONSTS_VH
`define DMAHP_CONSTS_VH

// ---------------------------------------------------------------
// Register indices on the software port
// ---------------------------------------------------------------
`define DMAHP_REG_CTRL 3'h0
`define DMAHP_REG_WAIT 3'h1
`define DMAHP_REG_ADDR 3'h2
`define DMAHP_REG_COUNT 3'h3
`define DMAHP_REG_WDATA 3'h4
`define DMAHP_REG_RDATA 3'h5
`define DMAHP_REG_STATUS 3'h6

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DMAHP_CTRL_EN 0
`define DMAHP_CTRL_MODE_LO 1
`define DMAHP_CTRL_MODE_HI 2
`define DMAHP_CTRL_DIR 3
`define DMAHP_WAIT_CNT_HI 2
`define DMAHP_WAIT_HOLD 3
`define DMAHP_STAT_BUSY 0
`define DMAHP_STAT_DONE 1
`define DMAHP_MS_LO 26
`define DMAHP_MS_HI 27
`define DMAHP_PAGE_LO 8

// ---------------------------------------------------------------
// Modes and states
// ---------------------------------------------------------------
`define DMAHP_MODE_HS 2'h0
`define DMAHP_MODE_EXT 2'h1
`define DMAHP_MODE_PACED 2'h2
`define DMAHP_ST_IDLE 2'h0
`define DMAHP_ST_ACCESS 2'h1
`define DMAHP_ST_END 2'h2
`define DMAHP_ST_GAP 2'h3

// ---------------------------------------------------------------
// Reset values and small constants
// ---------------------------------------------------------------
`define DMAHP_ZERO32 32'h00000000
`define DMAHP_ONE32 32'h00000001
`define DMAHP_CTRL_RST 4'h0
`define DMAHP_WAIT_RST 4'h0
`define DMAHP_WAIT_ZERO 3'h0
`define DMAHP_WAIT_ONE 3'h1
`define DMAHP_MS_NONE 4'hF
`define DMAHP_PAGE_RST 24'h000000

`endif

// File: rtl/dmahp_req_detect.v
// Request sampler for the DMA handshake port.
// Assumes the request pin is synchronous to CLK_SYS.
`timescale 1ns/10ps
module dmahp_req_detect (
    input wire clk_sys,
    input wire rst,
    input wire dma_request_n,
    output wire req_low,
    output wire req_fall
);
    reg req_q_r;
    reg req_prev_r;

    // ---------------------------------------------------------------
    // Sampling
    // ---------------------------------------------------------------
    // A level that met setup appears in req_q_r after the edge that took it.
    always @(posedge clk_sys) begin
        if (rst) begin
            req_q_r <= 1'b1;
            req_prev_r <= 1'b1;
        end else begin
            req_q_r <= dma_request_n;
            req_prev_r <= req_q_r;
        end
    end

    assign req_low = ~req_q_r;
    // Only a new high-to-low edge counts, so a held request is one request.
    assign req_fall = ~req_q_r & req_prev_r;
endmodule

// File: dv/dmahp_checker.sv
// Assertions on the pins of the DMA handshake port.
// Bound to dmahp_top; sees only its ports and shadows mode and wait.
`timescale 1ns/10ps
module dmahp_checker (
    input wire CLK_SYS,
    input wire RST,
    input wire [2:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire DMA_REQUEST_N,
    input wire RD_N,
    input wire WR_N,
    input wire SYNC_WRITE_SELECT_N,
    input wire [3:0] MEMORY_SELECT_N,
    input wire DMA_GRANT_N
);
    reg [1:0] mode_r;
    reg [3:0] wait_r;
    reg [4:0] glen_r;
    wire stb = !RD_N || !WR_N;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    always @(posedge CLK_SYS) begin
        if (RST) begin
            mode_r <= 2'h0;
            wait_r <= 4'h0;
        end else if (REG_WR && REG_ADDR == 3'h0) begin
            mode_r <= REG_WDATA[2:1];
        end else if (REG_WR && REG_ADDR == 3'h1) begin
            wait_r <= REG_WDATA[3:0];
        end
        glen_r <= DMA_GRANT_N ? 5'h00 : glen_r + 5'h01;
    end
    chk_strobe_nested:
        assert property (stb && mode_r != 2'h2 |-> !DMA_GRANT_N) else $error("strobe outside grant");
    chk_strobe_first:
        assert property ($rose(DMA_GRANT_N) |-> $past(RD_N && WR_N)) else $error("strobe after grant");
    chk_paced_nogrant:
        assert property (mode_r == 2'h2 |-> DMA_GRANT_N) else $error("grant in paced mode");
    chk_hs_grant_only:
        assert property (mode_r == 2'h0 |-> RD_N && WR_N && MEMORY_SELECT_N == 4'hF) else $error("strobe in hs");
    chk_ext_pins_set:
        assert property (mode_r == 2'h1 && stb |-> !DMA_GRANT_N && SYNC_WRITE_SELECT_N == WR_N
            && $onehot(~MEMORY_SELECT_N)) else $error("ext pins wrong");
    chk_grant_cause:
        assert property ($fell(DMA_GRANT_N) |-> !$past(DMA_REQUEST_N, 2) || !$past(DMA_REQUEST_N, 3))
        else $error("grant without request");
    chk_write_holdoff:
        assert property ($rose(WR_N) |-> $past(DMA_REQUEST_N, 2)) else $error("write ended under request");
    chk_read_prolong:
        assert property ($rose(RD_N) |-> $past(DMA_REQUEST_N, 2)) else $error("read ended under request");
    chk_wait_length:
        assert property ($rose(DMA_GRANT_N) |-> glen_r >= {2'h0, wait_r[2:0]} + 5'h02) else $error("grant short");
    chk_idle_gap:
        assert property ($rose(DMA_GRANT_N) && wait_r[3] |-> ##1 DMA_GRANT_N && RD_N && WR_N)
        else $error("no idle cycle");
endmodule
bind dmahp_top dmahp_checker chk (.CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .DMA_REQUEST_N(DMA_REQUEST_N), .RD_N(RD_N), .WR_N(WR_N),
    .SYNC_WRITE_SELECT_N(SYNC_WRITE_SELECT_N), .MEMORY_SELECT_N(MEMORY_SELECT_N), .DMA_GRANT_N(DMA_GRANT_N));

// File: dv/dmahp_requester.sv
// Model of the external requester facing the DMA port.
// Driven by the bench through go, hold and ack_wait.
`timescale 1ns/10ps
module dmahp_requester #(
    parameter [31:0] WORD = 32'hC3A50F1E
) (
    input wire clk,
    input wire rst,
    input wire go,
    input wire [3:0] hold,
    input wire [3:0] ack_wait,
    input wire rd_n,
    input wire wr_n,
    input wire grant_n,
    output reg req_n,
    output wire ack,
    output wire [31:0] data_in
);
    reg [3:0] cnt_r;
    reg [3:0] acnt_r;
    assign ack = acnt_r >= ack_wait;
    // Outside the data phase the inverted word shows, so an early sample is caught.
    assign data_in = (req_n && (!grant_n || !rd_n)) ? WORD : ~WORD;
    always @(posedge clk) begin
        if (rst) begin
            req_n <= 1'b1;
            cnt_r <= 4'h0;
            acnt_r <= 4'h0;
        end else begin
            acnt_r <= (!rd_n || !wr_n) ? acnt_r + 4'h1 : 4'h0;
            if (go) begin
                req_n <= 1'b0;
                cnt_r <= hold;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end else begin
                req_n <= 1'b1;
            end
        end
    end
endmodule

// File: dv/dmahp_top_test.sv
// Bench of the DMA handshake port with the requester model.
// Assumes every transfer ends within the 40-cycle window.
`timescale 1ns/10ps
module dmahp_top_test;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg go = 1'b0;
    reg [2:0] ad = 3'h0;
    reg [31:0] wd = 32'h0;
    reg [3:0] hold = 4'h0;
    reg [3:0] aw = 4'h0;
    reg [31:0] v;
    wire [31:0] rdat, din, dout, aout;
    wire req_n, ack, oe, rd_n, wr_n, sw_n, pg, gnt_n;
    wire [3:0] ms_n;
    integer errors = 0;
    integer samples_checked = 0;
    integer glen, slen, gp, i, pgn, oen;
    dmahp_top uut (.CLK_SYS(clk), .RST(rst), .REG_ADDR(ad), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdat), .DMA_REQUEST_N(req_n), .ACK(ack), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
        .ADDR_OUT(aout), .RD_N(rd_n), .WR_N(wr_n), .SYNC_WRITE_SELECT_N(sw_n), .PAGE(pg),
        .MEMORY_SELECT_N(ms_n), .DMA_GRANT_N(gnt_n));
    dmahp_requester far (.clk(clk), .rst(rst), .go(go), .hold(hold), .ack_wait(aw), .rd_n(rd_n),
        .wr_n(wr_n), .grant_n(gnt_n), .req_n(req_n), .ack(ack), .data_in(din));
    initial forever #25 clk = ~clk;
    task summarize;
        begin
            $display("errors %0d samples_checked %0d", errors, samples_checked);
            if (errors == 0 && samples_checked > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wreg(input [2:0] a, input [31:0] d);
        begin
            @(posedge clk);
            ad <= a;
            wd <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rreg(input [2:0] a);
        begin
            @(posedge clk);
            ad <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            @(negedge clk);
            v = rdat;
        end
    endtask
    // Fires one request and counts grant cycles, strobe cycles and grant pulses.
    task fire(input [3:0] h, input [3:0] k);
        reg gprev;
        begin
            @(posedge clk);
            hold <= h;
            aw <= k;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            glen = 0;
            slen = 0;
            gp = 0;
            pgn = 0;
            oen = 0;
            gprev = 1'b1;
            for (i = 0; i < 40; i = i + 1) begin
                @(negedge clk);
                glen = glen + (gnt_n === 1'b0);
                slen = slen + (rd_n === 1'b0 || wr_n === 1'b0);
                gp = gp + (gprev === 1'b1 && gnt_n === 1'b0);
                pgn = pgn + (pg === 1'b1);
                oen = oen + (oe === 1'b1);
                gprev = gnt_n;
            end
        end
    endtask
    task run(input [31:0] c, input [31:0] w, input [3:0] h, input [3:0] k);
        begin
            wreg(3'h1, w);
            wreg(3'h2, 32'h04000010);
            wreg(3'h3, 32'h00000001);
            wreg(3'h0, c);
            fire(h, k);
        end
    endtask
    task t_regs;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                rreg(i[2:0]);
                check(v, 32'h0);
            end
            wreg(3'h7, 32'hFFFFFFFF);
            rreg(3'h7);
            check(v, 32'h0);
        end
    endtask
    task t_ext_read;
        begin
            run(32'h3, 32'h0, 4'h0, 4'h0);
            check(glen, 32'h2);
            check(gp, 32'h1);
            check(pgn, 32'h1);
            check(oen, 32'h0);
            check(aout, 32'h04000010);
            rreg(3'h5);
            check(v, 32'hC3A50F1E);
            rreg(3'h2);
            check(v, 32'h04000011);
            rreg(3'h6);
            check(v, 32'h2);
            fire(4'h0, 4'h0);
            check(gp, 32'h0);
        end
    endtask
    task t_wait;
        begin
            run(32'h3, 32'hB, 4'h0, 4'h0);
            check(glen, 32'h5);
            check(slen, 32'h4);
            check(pgn, 32'h0);
        end
    endtask
    task t_stretch;
        begin
            run(32'h3, 32'h0, 4'h5, 4'h0);
            check(glen >= 5, 32'h1);
            rreg(3'h5);
            check(v, 32'hC3A50F1E);
            wreg(3'h4, 32'h5A5A1234);
            run(32'hB, 32'h0, 4'h5, 4'h0);
            check(glen >= 5, 32'h1);
            check(slen, glen - 1);
            check(oen, glen);
            check(dout, 32'h5A5A1234);
        end
    endtask
    task t_modes;
        begin
            run(32'h1, 32'h0, 4'h0, 4'h0);
            check(slen, 32'h0);
            check(gp, 32'h1);
            rreg(3'h5);
            check(v, 32'hC3A50F1E);
            run(32'h5, 32'h0, 4'h0, 4'h2);
            check(gp, 32'h0);
            check(slen, 32'h3);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_ext_read;
        t_wait;
        t_stretch;
        t_modes;
        summarize;
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors = errors + 1;
        summarize;
    end
endmodule
